// >>> rtl/lcd_cfg_pkg.sv
// constants for the indirect configuration command decoder
package lcd_cfg_pkg;
    // command codes
    localparam logic [7:0] CMD_SYSTEM_SETUP = 8'h40;
    localparam logic [7:0] CMD_SCROLL = 8'h44;
    localparam logic [7:0] CMD_HSHIFT = 8'h5A;
    localparam logic [7:0] CMD_OVERLAY = 8'h5B;
    // register offsets
    localparam logic [4:0] OFS_SYSTEM_MODE_FLAGS = 5'h00;
    localparam logic [4:0] OFS_CHAR_WIDTH_AND_DRIVE = 5'h01;
    localparam logic [4:0] OFS_CHAR_HEIGHT = 5'h02;
    localparam logic [4:0] OFS_LINE_DISPLAY_ADDRESSES = 5'h03;
    localparam logic [4:0] OFS_LINE_TOTAL_ADDRESSES = 5'h04;
    localparam logic [4:0] OFS_FRAME_LINE_COUNT = 5'h05;
    localparam logic [4:0] OFS_VIRTUAL_WIDTH_LOW = 5'h06;
    localparam logic [4:0] OFS_VIRTUAL_WIDTH_HIGH = 5'h07;
    localparam logic [4:0] OFS_BLOCK1_START_LOW = 5'h0B;
    localparam logic [4:0] OFS_BLOCK1_START_HIGH = 5'h0C;
    localparam logic [4:0] OFS_BLOCK1_LINE_COUNT = 5'h0D;
    localparam logic [4:0] OFS_BLOCK2_START_LOW = 5'h0E;
    localparam logic [4:0] OFS_BLOCK2_START_HIGH = 5'h0F;
    localparam logic [4:0] OFS_BLOCK2_LINE_COUNT = 5'h10;
    localparam logic [4:0] OFS_BLOCK3_START_LOW = 5'h11;
    localparam logic [4:0] OFS_BLOCK3_START_HIGH = 5'h12;
    localparam logic [4:0] OFS_BLOCK4_START_LOW = 5'h13;
    localparam logic [4:0] OFS_BLOCK4_START_HIGH = 5'h14;
    localparam logic [4:0] OFS_LAYER_OVERLAY_MODE = 5'h18;
    localparam logic [4:0] OFS_HORIZONTAL_PIXEL_SHIFT = 5'h1B;
    // parameter counts per command
    localparam logic [3:0] LEN_SYSTEM_SETUP = 4'h8;
    localparam logic [3:0] LEN_SCROLL = 4'hA;
    localparam logic [3:0] LEN_SINGLE = 4'h1;
    // field positions
    localparam int POS_FONT_SOURCE = 0;
    localparam int POS_CHAR_HEIGHT_SEL = 2;
    localparam int POS_TWO_PANEL = 3;
    localparam int POS_TOP_LINE_COMP = 5;
    localparam int POS_AC_DRIVE = 7;
    localparam int POS_BLOCK1_TG = 2;
    localparam int POS_BLOCK3_TG = 3;
    // reset value of every configuration register, and of the parameter counter
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [3:0] RST_COUNT = 4'h0;
endpackage : lcd_cfg_pkg

// >>> rtl/lcd_indirect_config_cmds.sv
// command and parameter decoder that loads the display configuration registers
//
// Functional notes
// - byte select low writes a parameter byte; high writes a command byte.
// - system setup 40h fills register 00h onward; bit 0 selects internal font ROM.
// - register 00h bit 2 selects character height, 8 lines per character.
// - register 00h bit 3 set selects two-panel drive.
// - register 00h bit 5 controls top-line compensation; 38h disables it.
// - register 01h bits 3-0 hold character width minus one.
// - register 01h bit 7 set selects two-frame AC drive.
// - register 02h bits 3-0 hold character height minus one.
// - register 03h holds display addresses per line minus one.
// - register 04h holds total addresses per line including blanking.
// - register 05h holds display lines per frame minus one.
// - registers 06h low and 07h high hold virtual screen width.
// - scroll 44h loads block 1 start into 0Bh low then 0Ch high.
// - register 0Dh holds line count of block 1.
// - block 2 start goes to 0Eh/0Fh, its line count to 10h.
// - blocks 3 and 4 starts go low first to 11h/12h and 13h/14h.
// - shift command 5Ah stores 3-bit pixel shift in register 1Bh bits 2-0.
// - overlay command 5Bh stores composition method in register 18h bits 1-0.
// - register 18h bits 2 and 3 select text or graphics for blocks 1, 3.
`timescale 1ns/10ps

module lcd_indirect_config_cmds
    import lcd_cfg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // host byte bus
    input wire logic write_strobe,
    input wire logic byte_select_line,
    input wire logic [7:0] host_data,
    // decoder status
    output logic [7:0] active_cmd,
    output logic param_error,
    // system setup fields
    output logic font_source_select,
    output logic char_height_select,
    output logic two_panel_drive,
    output logic top_line_comp,
    output logic [3:0] char_width_field,
    output logic ac_drive_select,
    output logic [3:0] char_height_field,
    output logic [7:0] line_display_addresses,
    output logic [7:0] line_total_addresses,
    output logic [7:0] frame_line_count,
    output logic [15:0] virtual_width,
    // screen blocks
    output logic [15:0] block1_start,
    output logic [7:0] block1_line_count,
    output logic [15:0] block2_start,
    output logic [7:0] block2_line_count,
    output logic [15:0] block3_start,
    output logic [15:0] block4_start,
    // overlay and shift
    output logic [1:0] overlay_method,
    output logic block1_text_graphics,
    output logic block3_text_graphics,
    output logic [2:0] horizontal_shift
);

    // ************************************************************
    // command tracking
    // ************************************************************
    typedef enum logic [1:0] {
        CMD_IDLE = 2'b00,
        CMD_TAKING = 2'b01,
        CMD_DONE = 2'b11
    } cmd_state_e;

    cmd_state_e state_reg, state_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [3:0] count_reg, count_next;
    logic error_reg, error_next;

    // parameter count of a known command, zero for commands handled elsewhere
    function automatic logic [3:0] cmd_length(input logic [7:0] code);
        case (code)
            CMD_SYSTEM_SETUP: cmd_length = LEN_SYSTEM_SETUP;
            CMD_SCROLL: cmd_length = LEN_SCROLL;
            CMD_HSHIFT: cmd_length = LEN_SINGLE;
            CMD_OVERLAY: cmd_length = LEN_SINGLE;
            default: cmd_length = RST_COUNT;
        endcase
    endfunction : cmd_length

    // register offset addressed by parameter number n of a command
    function automatic logic [4:0] param_offset(input logic [7:0] code, input logic [3:0] n);
        param_offset = OFS_SYSTEM_MODE_FLAGS;
        case (code)
            CMD_SYSTEM_SETUP: param_offset = OFS_SYSTEM_MODE_FLAGS + {1'b0, n};
            CMD_SCROLL: begin
                // scroll has no gap to skip between 0Bh..10h and 11h..14h: offsets are contiguous
                param_offset = OFS_BLOCK1_START_LOW + {1'b0, n};
            end
            CMD_HSHIFT: param_offset = OFS_HORIZONTAL_PIXEL_SHIFT;
            CMD_OVERLAY: param_offset = OFS_LAYER_OVERLAY_MODE;
            default: param_offset = OFS_SYSTEM_MODE_FLAGS;
        endcase
    endfunction : param_offset

    logic cmd_write, param_write, param_accept;
    logic [4:0] wr_offset;

    always_comb begin
        cmd_write = write_strobe && byte_select_line;
        param_write = write_strobe && !byte_select_line;
        param_accept = param_write && (state_reg == CMD_TAKING);
        wr_offset = param_offset(cmd_reg, count_reg);
        state_next = state_reg;
        cmd_next = cmd_reg;
        count_next = count_reg;
        error_next = error_reg;
        if (cmd_write) begin
            // a new command always restarts at its first field
            cmd_next = host_data;
            count_next = RST_COUNT;
            error_next = 1'b0;
            state_next = (cmd_length(host_data) != RST_COUNT) ? CMD_TAKING : CMD_IDLE;
        end else if (param_accept) begin
            count_next = count_reg + 4'h1;
            if (count_reg + 4'h1 == cmd_length(cmd_reg)) begin
                state_next = CMD_DONE;
            end
        end else if (param_write && state_reg == CMD_DONE) begin
            // surplus parameters are dropped so they cannot spill into other fields
            error_next = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= CMD_IDLE;
            cmd_reg <= RST_CFG;
            count_reg <= RST_COUNT;
            error_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            count_reg <= count_next;
            error_reg <= error_next;
        end
    end

    // ************************************************************
    // configuration register file
    // ************************************************************
    logic [7:0] cfg_reg [0:31];
    logic [7:0] cfg_next [0:31];

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            cfg_next[i] = cfg_reg[i];
        end
        if (param_accept) begin
            cfg_next[wr_offset] = host_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) begin
                cfg_reg[i] <= RST_CFG;
            end
        end else begin
            for (int i = 0; i < 32; i++) begin
                cfg_reg[i] <= cfg_next[i];
            end
        end
    end

    // ************************************************************
    // field outputs
    // ************************************************************
    // outputs are taken from the registers themselves, so they follow the write by one cycle
    always_comb begin
        active_cmd = cmd_reg;
        param_error = error_reg;
        font_source_select = cfg_reg[OFS_SYSTEM_MODE_FLAGS][POS_FONT_SOURCE];
        char_height_select = cfg_reg[OFS_SYSTEM_MODE_FLAGS][POS_CHAR_HEIGHT_SEL];
        two_panel_drive = cfg_reg[OFS_SYSTEM_MODE_FLAGS][POS_TWO_PANEL];
        top_line_comp = cfg_reg[OFS_SYSTEM_MODE_FLAGS][POS_TOP_LINE_COMP];
        char_width_field = cfg_reg[OFS_CHAR_WIDTH_AND_DRIVE][3:0];
        ac_drive_select = cfg_reg[OFS_CHAR_WIDTH_AND_DRIVE][POS_AC_DRIVE];
        char_height_field = cfg_reg[OFS_CHAR_HEIGHT][3:0];
        line_display_addresses = cfg_reg[OFS_LINE_DISPLAY_ADDRESSES];
        line_total_addresses = cfg_reg[OFS_LINE_TOTAL_ADDRESSES];
        frame_line_count = cfg_reg[OFS_FRAME_LINE_COUNT];
        virtual_width = {cfg_reg[OFS_VIRTUAL_WIDTH_HIGH], cfg_reg[OFS_VIRTUAL_WIDTH_LOW]};
        block1_start = {cfg_reg[OFS_BLOCK1_START_HIGH], cfg_reg[OFS_BLOCK1_START_LOW]};
        block1_line_count = cfg_reg[OFS_BLOCK1_LINE_COUNT];
        block2_start = {cfg_reg[OFS_BLOCK2_START_HIGH], cfg_reg[OFS_BLOCK2_START_LOW]};
        block2_line_count = cfg_reg[OFS_BLOCK2_LINE_COUNT];
        block3_start = {cfg_reg[OFS_BLOCK3_START_HIGH], cfg_reg[OFS_BLOCK3_START_LOW]};
        block4_start = {cfg_reg[OFS_BLOCK4_START_HIGH], cfg_reg[OFS_BLOCK4_START_LOW]};
        overlay_method = cfg_reg[OFS_LAYER_OVERLAY_MODE][1:0];
        block1_text_graphics = cfg_reg[OFS_LAYER_OVERLAY_MODE][POS_BLOCK1_TG];
        block3_text_graphics = cfg_reg[OFS_LAYER_OVERLAY_MODE][POS_BLOCK3_TG];
        horizontal_shift = cfg_reg[OFS_HORIZONTAL_PIXEL_SHIFT][2:0];
    end

endmodule : lcd_indirect_config_cmds

// >>> dv/lcd_indirect_config_cmds_props.sv
// checker for the configuration command decoder ports
`timescale 1ns/10ps
module lcd_indirect_config_cmds_props
    import lcd_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic write_strobe,
    input wire logic byte_select_line,
    input wire logic [7:0] host_data,
    input wire logic [7:0] active_cmd,
    input wire logic param_error,
    input wire logic font_source_select,
    input wire logic char_height_select,
    input wire logic two_panel_drive,
    input wire logic top_line_comp,
    input wire logic [3:0] char_width_field,
    input wire logic ac_drive_select,
    input wire logic [1:0] overlay_method,
    input wire logic block1_text_graphics,
    input wire logic block3_text_graphics,
    input wire logic [2:0] horizontal_shift,
    input wire logic [15:0] block1_start,
    input wire logic [15:0] block4_start,
    input wire logic [15:0] virtual_width
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic cmd, prm;
    assign cmd = write_strobe && byte_select_line;
    assign prm = write_strobe && !byte_select_line;
    property p_cmd; cmd |=> active_cmd == $past(host_data) && !param_error; endproperty
    a_cmd: assert property (p_cmd) else $error("command byte not taken");
    property p_quiet; !prm |=> $stable(block1_start) && $stable(virtual_width) && $stable(horizontal_shift); endproperty
    a_quiet: assert property (p_quiet) else $error("field changed without a parameter");
    property p_setup1; cmd && host_data == CMD_SYSTEM_SETUP ##1 prm |=> {top_line_comp, two_panel_drive,
        char_height_select, font_source_select} == {$past(host_data[5]), $past(host_data[3:2]), $past(host_data[0])};
    endproperty
    a_setup1: assert property (p_setup1) else $error("setup flags wrong");
    property p_setup2; cmd && host_data == CMD_SYSTEM_SETUP ##1 prm [*2] |=>
        char_width_field == $past(host_data[3:0]) && ac_drive_select == $past(host_data[7]); endproperty
    a_setup2: assert property (p_setup2) else $error("width or drive wrong");
    property p_scroll; cmd && host_data == CMD_SCROLL ##1 prm |=> block1_start[7:0] == $past(host_data); endproperty
    a_scroll: assert property (p_scroll) else $error("block 1 start low wrong");
    property p_shift; cmd && host_data == CMD_HSHIFT ##1 prm |=> horizontal_shift == $past(host_data[2:0]); endproperty
    a_shift: assert property (p_shift) else $error("pixel shift wrong");
    property p_ovl; cmd && host_data == CMD_OVERLAY ##1 prm |=> {block3_text_graphics, block1_text_graphics,
        overlay_method} == $past(host_data[3:0]); endproperty
    a_ovl: assert property (p_ovl) else $error("overlay mode wrong");
    property p_over; cmd && host_data == CMD_HSHIFT ##1 prm ##1 prm |=> param_error && $stable(horizontal_shift);
    endproperty
    a_over: assert property (p_over) else $error("extra parameter not refused");
    c_setup: cover property (cmd && host_data == CMD_SYSTEM_SETUP ##1 prm [*8]);
    c_scroll: cover property (cmd && host_data == CMD_SCROLL ##1 prm [*8] ##1 prm [*2]);
    c_err: cover property ($rose(param_error));
endmodule : lcd_indirect_config_cmds_props
bind lcd_indirect_config_cmds lcd_indirect_config_cmds_props chk (.clk, .reset, .write_strobe, .byte_select_line,
    .host_data, .active_cmd, .param_error, .font_source_select, .char_height_select, .two_panel_drive,
    .top_line_comp, .char_width_field, .ac_drive_select, .overlay_method, .block1_text_graphics,
    .block3_text_graphics, .horizontal_shift, .block1_start, .block4_start, .virtual_width);

// >>> dv/lcd_host_model.sv
// host bus model writing command and parameter bytes
`timescale 1ns/10ps
module lcd_host_model (
    input wire logic clk,
    output logic write_strobe,
    output logic byte_select_line,
    output logic [7:0] host_data
);
    initial begin
        write_strobe = 1'b0;
        byte_select_line = 1'b0;
        host_data = 8'h00;
    end
    task automatic send(input logic sel, input logic [7:0] d);
        @(negedge clk);
        write_strobe = 1'b1;
        byte_select_line = sel;
        host_data = d;
    endtask : send
    // released bus shows a toggled pattern, never the last byte
    task automatic idle();
        @(negedge clk);
        write_strobe = 1'b0;
        host_data = ~host_data;
    endtask : idle
endmodule : lcd_host_model

// >>> dv/tb_lcd_indirect_config_cmds.sv
// self-checking bench for the configuration command decoder
`timescale 1ns/10ps
module tb_lcd_indirect_config_cmds;
    import lcd_cfg_pkg::*;
    logic clk, reset, write_strobe, byte_select_line, param_error, font_source_select, char_height_select;
    logic two_panel_drive, top_line_comp, ac_drive_select, block1_text_graphics, block3_text_graphics;
    logic [1:0] overlay_method;
    logic [2:0] horizontal_shift;
    logic [3:0] char_width_field, char_height_field;
    logic [7:0] host_data, active_cmd, line_display_addresses, line_total_addresses, frame_line_count;
    logic [7:0] block1_line_count, block2_line_count;
    logic [15:0] virtual_width, block1_start, block2_start, block3_start, block4_start;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    lcd_host_model host (.clk, .write_strobe, .byte_select_line, .host_data);
    lcd_indirect_config_cmds dut (.clk, .reset, .write_strobe, .byte_select_line, .host_data, .active_cmd,
        .param_error, .font_source_select, .char_height_select, .two_panel_drive, .top_line_comp,
        .char_width_field, .ac_drive_select, .char_height_field, .line_display_addresses, .line_total_addresses,
        .frame_line_count, .virtual_width, .block1_start, .block1_line_count, .block2_start, .block2_line_count,
        .block3_start, .block4_start, .overlay_method, .block1_text_graphics, .block3_text_graphics,
        .horizontal_shift);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic end_sim();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // command, then n parameters back to back, then bus released
    task automatic wr(input logic [7:0] c, input int n, input logic [7:0] p[10]);
        host.send(1'b1, c);
        for (int i = 0; i < n; i++) host.send(1'b0, p[i]);
        host.idle();
    endtask : wr
    task automatic t_setup();
        wr(CMD_SYSTEM_SETUP, 8, '{8'h38, 8'h87, 8'h07, 8'h3F, 8'h49, 8'h7F, 8'h80, 8'h00, 8'h00, 8'h00});
        chk({font_source_select, char_height_select, two_panel_drive, top_line_comp}, 16'h0003);
        chk({ac_drive_select, char_width_field, char_height_field}, 16'h0177);
        chk({line_display_addresses, line_total_addresses}, 16'h3F49);
        chk({frame_line_count, 8'h00}, 16'h7F00);
        chk(virtual_width, 16'h0080);
        wr(CMD_SYSTEM_SETUP, 1, '{8'h25, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        chk({font_source_select, char_height_select, two_panel_drive, top_line_comp}, 16'h000D);
        chk(virtual_width, 16'h0080);
    endtask : t_setup
    task automatic t_scroll();
        wr(CMD_SCROLL, 10, '{8'h00, 8'h00, 8'h40, 8'h00, 8'h10, 8'h40, 8'h00, 8'h04, 8'h00, 8'h30});
        chk(block1_start, 16'h0000);
        chk({block1_line_count, block2_line_count}, 16'h4040);
        chk(block2_start, 16'h1000);
        chk(block3_start, 16'h0400);
        chk(block4_start, 16'h3000);
    endtask : t_scroll
    task automatic t_shift_overlay();
        wr(CMD_HSHIFT, 2, '{8'h05, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        chk({param_error, 1'b0, horizontal_shift}, 16'h0015);
        wr(CMD_OVERLAY, 1, '{8'h0D, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        chk({param_error, block3_text_graphics, block1_text_graphics, overlay_method}, 16'h000D);
        wr(CMD_HSHIFT, 1, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        wr(CMD_OVERLAY, 1, '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        chk({horizontal_shift, block3_text_graphics, block1_text_graphics, overlay_method}, 16'h0001);
    endtask : t_shift_overlay
    task automatic t_restart_unknown();
        wr(CMD_SCROLL, 2, '{8'hAA, 8'hBB, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        wr(CMD_SCROLL, 1, '{8'hCC, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        chk(block1_start, 16'hBBCC);
        // layer clear by memory write: the fill byte must not land in any field
        wr(8'h42, 1, '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        chk({active_cmd, 5'h00, horizontal_shift}, 16'h4200);
    endtask : t_restart_unknown
    initial begin
        reset = 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        chk({active_cmd, param_error, horizontal_shift}, 16'h0000);
        chk(block4_start | virtual_width, 16'h0000);
        t_setup();
        t_scroll();
        t_shift_overlay();
        t_restart_unknown();
        end_sim();
    end
endmodule : tb_lcd_indirect_config_cmds
